// [src/kli_keypad_irq.sv]
// Purpose: Eight-line level-sensitive keypad interrupt logic with its three registers.
// Assumes: Core special-function register port, one access per strobe, one clock.
// Notes:   Detection is by level, so a held key re-arms its flag every clock.
//
// Function
// [R1] A line's flag sets whenever its synchronised pin matches its polarity.
// [R2] Flags request the shared interrupt only where the line's enable bit is one.
// [R3] Reading the flag register clears flags of lines 0, 1 and 3 to 7.
// [R4] Line 2 flag survives reads; software clears it by writing the flag register.
// [R5] Enable zero leaves the pin plain I/O; enable one lets it interrupt.
// [R6] Polarity zero makes the line detect a low level.
// [R7] Polarity one makes the line detect a high level.
// [R8] Reset loads zero into flag, enable and polarity registers.
// [R9] All three registers are 8 bits, bit n serving port line n.
// [R10] All lines OR onto one request, gated by the global enable.
// [R11] A detected level on an enabled line raises a wake-up event.
// [R12] Pins pass two flip-flops; a cleared flag re-sets while the level holds.

`timescale 1ns/1ps

module kli_keypad_irq #(
   parameter int unsigned LINES = kli_pkg::LINE_COUNT
) (
   // Clock and reset
   input  wire logic                          clock,
   input  wire logic                          rst,
   // Special-function register port
   input  wire kli_pkg::kli_sfr_req_t         sfr_req,
   output logic      [kli_pkg::DATA_W-1:0]    sfr_rdata,
   // Port pins and alternate-function select
   input  wire logic [LINES-1:0]              key_pins,
   output logic      [LINES-1:0]              key_line_alt_select,
   // Core interrupt and power control
   input  wire logic                          keypad_global_irq_enable,
   output logic                               keypad_irq_request,
   output logic                               keypad_wake
);

   // ***********************************************************************
   // Address decoding
   // ***********************************************************************

   function automatic logic hits(
      input logic [kli_pkg::ADDR_W-1:0] addr,
      input logic [kli_pkg::ADDR_W-1:0] target
   );
      hits = (addr == target);
   endfunction : hits

   logic sel_polarity;
   logic sel_enable;
   logic sel_flags;

   always_comb begin
      sel_polarity = hits(sfr_req.addr, kli_pkg::KEY_LINE_POLARITY_OFFS);
      sel_enable   = hits(sfr_req.addr, kli_pkg::KEY_LINE_ENABLE_OFFS);
      sel_flags    = hits(sfr_req.addr, kli_pkg::KEY_LINE_FLAGS_OFFS);
   end

   // ***********************************************************************
   // Pin synchronisation and level detection
   // ***********************************************************************

   logic [LINES-1:0] pins_sync;
   logic [LINES-1:0] level_match;

   // Pins come from outside the clock domain and are never read before this.
   kli_sync2 #(
      .WIDTH    (LINES)
   ) u_sync (
      .clock    (clock),
      .rst      (rst),
      .async_in (key_pins),
      .sync_out (pins_sync)
   ); // R12

   logic [LINES-1:0] key_line_polarity_reg;
   logic [LINES-1:0] key_line_polarity_next;
   logic [LINES-1:0] key_line_enable_reg;
   logic [LINES-1:0] key_line_enable_next;
   logic [LINES-1:0] key_line_flags_reg;
   logic [LINES-1:0] key_line_flags_next;

   // A line matches when its pin equals its polarity bit: low for zero, high for one.
   genvar gi;
   generate
      for (gi = 0; gi < LINES; gi++) begin : g_detect
         assign level_match[gi] = key_line_polarity_reg[gi] ? pins_sync[gi]    // R7
                                                           : ~pins_sync[gi];  // R6
      end
   endgenerate

   // ***********************************************************************
   // Register file
   // ***********************************************************************

   logic [LINES-1:0] read_clear;
   logic [LINES-1:0] write_keep;

   always_comb begin
      key_line_polarity_next = key_line_polarity_reg;
      key_line_enable_next   = key_line_enable_reg;
      read_clear             = '0;
      write_keep             = '1;

      if (sfr_req.wr && sel_polarity) begin
         key_line_polarity_next = sfr_req.wdata[LINES-1:0]; // R9
      end
      if (sfr_req.wr && sel_enable) begin
         key_line_enable_next = sfr_req.wdata[LINES-1:0]; // R9
      end

      // Reading clears every flag except the sticky line.
      if (sfr_req.rd && sel_flags) begin
         read_clear = kli_pkg::READ_CLEAR_MASK[LINES-1:0]; // R3
      end
      // A written zero clears that flag; a written one leaves it alone.
      if (sfr_req.wr && sel_flags) begin
         write_keep = sfr_req.wdata[LINES-1:0]; // R4
      end

      // A level present in the clearing cycle wins over the clear.
      key_line_flags_next = (key_line_flags_reg & ~read_clear & write_keep)
                          | level_match; // R1 R12
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         key_line_polarity_reg <= kli_pkg::KEY_LINE_POLARITY_RST[LINES-1:0]; // R8
         key_line_enable_reg   <= kli_pkg::KEY_LINE_ENABLE_RST[LINES-1:0];   // R8
         key_line_flags_reg    <= kli_pkg::KEY_LINE_FLAGS_RST[LINES-1:0];    // R8
      end else begin
         key_line_polarity_reg <= key_line_polarity_next;
         key_line_enable_reg   <= key_line_enable_next;
         key_line_flags_reg    <= key_line_flags_next;
      end
   end

   // ***********************************************************************
   // Read data
   // ***********************************************************************

   logic [kli_pkg::DATA_W-1:0] rdata_reg;
   logic [kli_pkg::DATA_W-1:0] rdata_next;

   // Read data shows the flags as they stood before the read cleared them.
   always_comb begin
      rdata_next = rdata_reg;
      if (sfr_req.rd) begin
         if (sel_polarity) begin
            rdata_next = kli_pkg::DATA_W'(key_line_polarity_reg);
         end else if (sel_enable) begin
            rdata_next = kli_pkg::DATA_W'(key_line_enable_reg);
         end else if (sel_flags) begin
            rdata_next = kli_pkg::DATA_W'(key_line_flags_reg);
         end else begin
            rdata_next = kli_pkg::UNMAPPED_READ_VALUE;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_reg <= kli_pkg::UNMAPPED_READ_VALUE;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign sfr_rdata = rdata_reg;

   // ***********************************************************************
   // Interrupt request and wake-up
   // ***********************************************************************

   logic irq_reg;
   logic irq_next;
   logic wake_reg;
   logic wake_next;

   // Both are registered, so each follows its cause by one clock.
   always_comb begin
      irq_next  = keypad_global_irq_enable
                & (|(key_line_flags_reg & key_line_enable_reg)); // R2 R5 R10
      // Wake does not wait on the global enable: a stopped core must still wake.
      wake_next = |(level_match & key_line_enable_reg); // R11
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         irq_reg  <= 1'b0;
         wake_reg <= 1'b0;
      end else begin
         irq_reg  <= irq_next;
         wake_reg <= wake_next;
      end
   end

   assign keypad_irq_request  = irq_reg;
   assign keypad_wake         = wake_reg;
   // Enable zero hands the pin back to the port logic as ordinary I/O.
   assign key_line_alt_select = key_line_enable_reg; // R5

   // ***********************************************************************
   // Assertions
   // ***********************************************************************

   default clocking cb @(posedge clock);
   endclocking

   default disable iff (rst);

   property p_flag_sets;
      (level_match != '0) |=> ((key_line_flags_reg & $past(level_match))
                               == $past(level_match));
   endproperty
   a_flag_sets: assert property (p_flag_sets) // R1
      else $error("Matching level did not set its flag.");

   property p_sync_depth;
      1 ##2 1 |-> (pins_sync == $past(key_pins, 2));
   endproperty
   a_sync_depth: assert property (p_sync_depth) // R12
      else $error("Pin synchroniser depth is not two clocks.");

   property p_irq_masked;
      ((key_line_flags_reg & key_line_enable_reg) == '0) |=> !keypad_irq_request;
   endproperty
   a_irq_masked: assert property (p_irq_masked) // R2
      else $error("Interrupt raised by a masked flag.");

   property p_irq_raised;
      (keypad_global_irq_enable && ((key_line_flags_reg & key_line_enable_reg) != '0))
         |=> keypad_irq_request;
   endproperty
   a_irq_raised: assert property (p_irq_raised) // R10
      else $error("Enabled flag did not raise the interrupt.");

   property p_global_gate;
      !keypad_global_irq_enable |=> !keypad_irq_request;
   endproperty
   a_global_gate: assert property (p_global_gate) // R10
      else $error("Interrupt raised while globally disabled.");

   property p_read_clears;
      (sfr_req.rd && sel_flags && !sfr_req.wr && level_match == '0)
         |=> ((key_line_flags_reg & kli_pkg::READ_CLEAR_MASK[LINES-1:0]) == '0);
   endproperty
   a_read_clears: assert property (p_read_clears) // R3
      else $error("Flag read did not clear the read-clear lines.");

   property p_sticky_survives;
      (sfr_req.rd && sel_flags && !sfr_req.wr && key_line_flags_reg[kli_pkg::STICKY_LINE])
         |=> key_line_flags_reg[kli_pkg::STICKY_LINE];
   endproperty
   a_sticky_survives: assert property (p_sticky_survives) // R4
      else $error("Sticky flag was cleared by a read.");

   property p_sticky_write;
      (sfr_req.wr && sel_flags && !sfr_req.wdata[kli_pkg::STICKY_LINE]
       && !level_match[kli_pkg::STICKY_LINE])
         |=> !key_line_flags_reg[kli_pkg::STICKY_LINE];
   endproperty
   a_sticky_write: assert property (p_sticky_write) // R4
      else $error("Write of zero did not clear the sticky flag.");

   property p_low_level;
      (!key_line_polarity_reg[0] && !pins_sync[0]) |=> key_line_flags_reg[0];
   endproperty
   a_low_level: assert property (p_low_level) // R6
      else $error("Low level missed with polarity zero.");

   property p_high_level;
      (key_line_polarity_reg[0] && pins_sync[0]) |=> key_line_flags_reg[0];
   endproperty
   a_high_level: assert property (p_high_level) // R7
      else $error("High level missed with polarity one.");

   property p_wake;
      ((level_match & key_line_enable_reg) != '0) |=> keypad_wake;
   endproperty
   a_wake: assert property (p_wake) // R11
      else $error("Enabled level did not raise wake.");

   property p_read_polarity;
      (sfr_req.rd && sel_polarity) |=> (sfr_rdata == kli_pkg::DATA_W'($past(key_line_polarity_reg)));
   endproperty
   a_read_polarity: assert property (p_read_polarity) // R9
      else $error("Polarity read returned the wrong value.");

   property p_reset_zero;
      @(posedge clock) disable iff (1'b0)
         rst |=> (key_line_flags_reg == '0 && key_line_enable_reg == '0
                  && key_line_polarity_reg == '0 && !keypad_irq_request);
   endproperty
   a_reset_zero: assert property (p_reset_zero) // R8
      else $error("Registers not zero after reset.");

endmodule : kli_keypad_irq

// [src/kli_pkg.sv]
// Purpose: Shared constants and types for the keypad level interrupt block.
// Assumes: An 8-bit special-function register port driven by the core.
// Notes:   All offsets are special-function register addresses.

package kli_pkg;

   // ***********************************************************************
   // Sizes
   // ***********************************************************************
   localparam int unsigned LINE_COUNT = 8;
   localparam int unsigned ADDR_W     = 8;
   localparam int unsigned DATA_W     = 8;

   // ***********************************************************************
   // Register offsets
   // ***********************************************************************
   localparam logic [ADDR_W-1:0] KEY_LINE_POLARITY_OFFS = 8'h9C;
   localparam logic [ADDR_W-1:0] KEY_LINE_ENABLE_OFFS   = 8'h9D;
   localparam logic [ADDR_W-1:0] KEY_LINE_FLAGS_OFFS    = 8'h9E;

   // ***********************************************************************
   // Reset values and field positions
   // ***********************************************************************
   localparam logic [DATA_W-1:0] KEY_LINE_POLARITY_RST = 8'h00;
   localparam logic [DATA_W-1:0] KEY_LINE_ENABLE_RST   = 8'h00;
   localparam logic [DATA_W-1:0] KEY_LINE_FLAGS_RST    = 8'h00;
   localparam logic [DATA_W-1:0] UNMAPPED_READ_VALUE   = 8'h00;

   // Line whose flag survives a read and is cleared only by a write.
   localparam int unsigned       STICKY_LINE           = 2;
   localparam logic [DATA_W-1:0] READ_CLEAR_MASK       = 8'hFB;

   // Synchroniser depth on the port inputs.
   localparam int unsigned       SYNC_STAGES           = 2;

   // ***********************************************************************
   // Carrier for one special-function register access
   // ***********************************************************************
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              wr;
      logic              rd;
      logic [DATA_W-1:0] wdata;
   } kli_sfr_req_t;

endpackage : kli_pkg

// [src/kli_sync2.sv]
// Purpose: Two flip-flop synchroniser for a group of asynchronous inputs.
// Assumes: Inputs change independently; each bit is a level.
// Notes:   The first stage is read by the second stage only.

`timescale 1ns/1ps

module kli_sync2 #(
   parameter int unsigned WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   // Asynchronous inputs
   input  wire logic [WIDTH-1:0] async_in,
   // Synchronised outputs
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] stable_reg;
   logic [WIDTH-1:0] stable_next;

   always_comb begin
      meta_next   = async_in;
      stable_next = meta_reg;
   end

   // Both stages reset to ones, the resting level of a released key line.
   // Resetting to zero would look like every key pressed to a low-level detector
   // and leave all flags pending right after reset.
   always_ff @(posedge clock) begin
      if (rst) begin
         meta_reg   <= '1;
         stable_reg <= '1;
      end else begin
         meta_reg   <= meta_next;
         stable_reg <= stable_next;
      end
   end

   assign sync_out = stable_reg;

endmodule : kli_sync2

// [tb/kli_key_matrix.sv]
// Purpose: Behavioural key matrix seen on the eight keypad port lines.
// Assumes: Each line idles at the opposite of its pressed level (pull resistor).
// Notes:   No bounce; a pressed key drives its line at once.

`timescale 1ns/1ps

module kli_key_matrix (
   // Key state from the bench
   input  wire logic [7:0] pressed,
   input  wire logic [7:0] press_level,
   // Port lines
   output logic      [7:0] pins
);
   // A released line rests at the inverse of its pressed level, never at a stale value.
   assign pins = ~(pressed ^ press_level);
endmodule : kli_key_matrix

// [tb/tb.sv]
// Purpose: Self-checking bench for the keypad level interrupt block.
// Assumes: Register port strobes last one cycle; read data settles one cycle later.
// Notes:   Key changes are given five cycles to pass the synchroniser and flags.

`timescale 1ns/1ps

module tb;
   // ***********************************************************************
   // Signals
   // ***********************************************************************
   logic                  clock;
   logic                  rst;
   logic                  glob_en;
   kli_pkg::kli_sfr_req_t req;
   logic [7:0]            rdata;
   logic [7:0]            pins;
   logic [7:0]            alt_sel;
   logic [7:0]            pressed;
   logic [7:0]            lvl;
   logic                  irq;
   logic                  wake;
   int                    err_count = 0;
   int                    n_checks  = 0;
   int                    cyc       = 0;

   kli_keypad_irq u_dut (
      .clock                    (clock),
      .rst                      (rst),
      .sfr_req                  (req),
      .sfr_rdata                (rdata),
      .key_pins                 (pins),
      .key_line_alt_select      (alt_sel),
      .keypad_global_irq_enable (glob_en),
      .keypad_irq_request       (irq),
      .keypad_wake              (wake)
   );

   kli_key_matrix u_keys (
      .pressed     (pressed),
      .press_level (lvl),
      .pins        (pins)
   );

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // ***********************************************************************
   // Tasks
   // ***********************************************************************
   task automatic end_sim;
      $display("TB: checks=%0d mismatches=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
         err_count++;
      end
   endtask : chk

   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
      @(posedge clock);
      req.wr <= 1'b0;
      @(negedge clock);
   endtask : sfr_wr

   task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clock);
      req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge clock);
      req.rd <= 1'b0;
      @(negedge clock);
      v = rdata;
   endtask : sfr_rd

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      sfr_rd(a, v);
      chk(v, exp);
   endtask : rd_chk

   task automatic key(input logic [7:0] p);
      @(posedge clock);
      pressed <= p;
      repeat (5) @(posedge clock);
      @(negedge clock);
   endtask : key

   // The whole sequence needs well under 1000 cycles.
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_count++;
         end_sim();
      end
   end

   // ***********************************************************************
   // Tests
   // ***********************************************************************
   initial begin
      rst     = 1'b1;
      req     = '0;
      glob_en = 1'b0;
      pressed = 8'h00;
      lvl     = 8'h00;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      rd_chk(kli_pkg::KEY_LINE_POLARITY_OFFS, 8'h00);
      rd_chk(kli_pkg::KEY_LINE_ENABLE_OFFS, 8'h00);
      // Released keys rest high, so no flag may be pending after reset.
      rd_chk(kli_pkg::KEY_LINE_FLAGS_OFFS, 8'h00);
      sfr_wr(kli_pkg::KEY_LINE_FLAGS_OFFS, 8'h00);
      rd_chk(kli_pkg::KEY_LINE_FLAGS_OFFS, 8'h00);
      $display("TB: test reset done");

      @(posedge clock) glob_en <= 1'b1;
      sfr_wr(kli_pkg::KEY_LINE_ENABLE_OFFS, 8'hFF);
      chk(alt_sel, 8'hFF);
      key(8'h08);
      chk({7'h00, irq}, 8'h01);
      chk({7'h00, wake}, 8'h01);
      rd_chk(kli_pkg::KEY_LINE_FLAGS_OFFS, 8'h08);
      rd_chk(kli_pkg::KEY_LINE_FLAGS_OFFS, 8'h08);
      key(8'h00);
      rd_chk(kli_pkg::KEY_LINE_FLAGS_OFFS, 8'h08);
      rd_chk(kli_pkg::KEY_LINE_FLAGS_OFFS, 8'h00);
      repeat (2) @(negedge clock);
      chk({7'h00, irq}, 8'h00);
      $display("TB: test low level done");

      key(8'hFF);
      key(8'h00);
      rd_chk(kli_pkg::KEY_LINE_FLAGS_OFFS, 8'hFF);
      rd_chk(kli_pkg::KEY_LINE_FLAGS_OFFS, 8'h04);
      rd_chk(kli_pkg::KEY_LINE_FLAGS_OFFS, 8'h04);
      sfr_wr(kli_pkg::KEY_LINE_FLAGS_OFFS, 8'hFB);
      rd_chk(kli_pkg::KEY_LINE_FLAGS_OFFS, 8'h00);
      $display("TB: test clear done");

      sfr_wr(kli_pkg::KEY_LINE_ENABLE_OFFS, 8'hFD);
      chk(alt_sel, 8'hFD);
      key(8'h02);
      chk({7'h00, irq}, 8'h00);
      chk({7'h00, wake}, 8'h00);
      key(8'h00);
      rd_chk(kli_pkg::KEY_LINE_FLAGS_OFFS, 8'h02);
      rd_chk(kli_pkg::KEY_LINE_ENABLE_OFFS, 8'hFD);
      $display("TB: test mask done");

      sfr_wr(kli_pkg::KEY_LINE_ENABLE_OFFS, 8'hFF);
      @(posedge clock) glob_en <= 1'b0;
      key(8'h01);
      chk({7'h00, irq}, 8'h00);
      chk({7'h00, wake}, 8'h01);
      @(posedge clock) glob_en <= 1'b1;
      repeat (2) @(negedge clock);
      chk({7'h00, irq}, 8'h01);
      key(8'h00);
      rd_chk(kli_pkg::KEY_LINE_FLAGS_OFFS, 8'h01);
      rd_chk(kli_pkg::KEY_LINE_FLAGS_OFFS, 8'h00);
      $display("TB: test global enable done");

      // Line 7 now rests low, which the low-level detector flags until polarity flips.
      @(posedge clock) lvl <= 8'h80;
      repeat (4) @(posedge clock);
      sfr_wr(kli_pkg::KEY_LINE_POLARITY_OFFS, 8'h80);
      rd_chk(kli_pkg::KEY_LINE_POLARITY_OFFS, 8'h80);
      rd_chk(kli_pkg::KEY_LINE_FLAGS_OFFS, 8'h80);
      rd_chk(kli_pkg::KEY_LINE_FLAGS_OFFS, 8'h00);
      key(8'h80);
      rd_chk(kli_pkg::KEY_LINE_FLAGS_OFFS, 8'h80);
      $display("TB: test high level done");

      sfr_wr(8'h9F, 8'h55);
      rd_chk(8'h9F, 8'h00);
      rd_chk(kli_pkg::KEY_LINE_ENABLE_OFFS, 8'hFF);
      $display("TB: test unmapped done");
      end_sim();
   end
endmodule : tb
